/* File: rtl/fpe_pkg.sv */
package fpe_pkg;

	// ==========================================================
	// Register offsets (byte addresses within the slave window)
	localparam logic [7:0] OFS_ADDR = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_USEC = 8'h0C;
	localparam logic [7:0] OFS_RIS = 8'h10;
	localparam logic [7:0] OFS_IMASK = 8'h14;
	localparam logic [7:0] OFS_MIS = 8'h18;
	localparam logic [7:0] OFS_PROT = 8'h1C;

	// ==========================================================
	// Field positions
	localparam int CTRL_ERASE = 0;
	localparam int CTRL_PROG = 1;
	localparam int CTRL_COMMIT = 2;
	localparam int STAT_BUSY = 0;
	localparam int STAT_FAIL = 1;
	localparam int INT_W = 2;
	localparam int INT_DONE = 0;
	localparam int ACCESS_MISC_IRQ = 1;
	localparam int USEC_W = 8;
	localparam int PROT_W = 2;

	// ==========================================================
	// Reset values and array geometry
	localparam logic [7:0] USEC_RST = 8'h64;
	localparam logic [1:0] IRQ_RST = 2'h0;
	localparam int BLOCK_SHIFT = 10;
	localparam int REGION_SHIFT = 11;
	localparam int WORD_SHIFT = 2;

	// ==========================================================
	// Access kinds on the read-check port
	localparam logic [1:0] ACC_FETCH = 2'h0;
	localparam logic [1:0] ACC_DATA = 2'h1;
	localparam logic [1:0] ACC_DEBUG = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		prot_unrestricted,
		prot_no_modify,
		prot_fetch_only
	} fpe_prot_t;

	typedef enum logic [1:0] {
		st_idle,
		st_rd_req,
		st_rd_take,
		st_busy_op
	} fpe_state_t;

endpackage : fpe_pkg

/* File: rtl/fpe_us_timer.sv */
// ==========================================================
// Microsecond timer: counts dur_us microseconds of usec_clks cycles
module fpe_us_timer #(
	parameter int DUR_W = 16
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic start,
	input wire logic [fpe_pkg::USEC_W-1:0] usec_clks,
	input wire logic [DUR_W-1:0] dur_us,
	output logic done
);
	logic run_reg;
	logic [fpe_pkg::USEC_W-1:0] clk_cnt_reg;
	logic [fpe_pkg::USEC_W-1:0] usec_reg;
	logic [DUR_W-1:0] us_left_reg;
	logic us_tick;

	// One microsecond has passed; a setting of zero counts as one
	assign us_tick = run_reg
		&& ((clk_cnt_reg + 8'h01) >= usec_reg || usec_reg == 8'h00);

	// Clock and microsecond counters, setting latched at start
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			run_reg <= 1'b0;
			clk_cnt_reg <= '0;
			usec_reg <= fpe_pkg::USEC_RST;
			us_left_reg <= '0;
		end
		else if (start)
		begin
			run_reg <= 1'b1;
			clk_cnt_reg <= '0;
			usec_reg <= usec_clks;
			us_left_reg <= (dur_us == '0) ? DUR_W'(1) : dur_us;
		end
		else
		begin
			if (us_tick)
			begin
				clk_cnt_reg <= '0;
				us_left_reg <= us_left_reg - DUR_W'(1);
				if (us_left_reg == DUR_W'(1))
					run_reg <= 1'b0;
			end
			else if (run_reg)
				clk_cnt_reg <= clk_cnt_reg + 8'h01;
		end
	end

	// Done in the last cycle of the count, so the pulse is not one too long
	assign done = us_tick && us_left_reg == DUR_W'(1);

endmodule : fpe_us_timer

/* File: rtl/fpe_ctrl.sv */
module fpe_ctrl #(
	parameter int ADDR_W = 15,
	parameter int DUR_W = 16,
	parameter int PROG_US = 20,
	parameter int ERASE_US = 12000
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic acc_valid,
	input wire logic [ADDR_W-1:0] acc_addr,
	input wire logic [1:0] acc_kind,
	output logic acc_deny,
	output logic [ADDR_W-1:0] fl_addr,
	output logic [31:0] fl_wdata,
	input wire logic [31:0] fl_rdata,
	output logic fl_rd,
	output logic fl_prog,
	output logic fl_erase,
	input wire logic [2*(2**(ADDR_W-11))-1:0] saved_prot,
	output logic prot_commit,
	output logic [2*(2**(ADDR_W-11))-1:0] prot_commit_map,
	output logic busy,
	output logic irq
);
	localparam int NUM_REGIONS = 2 ** (ADDR_W - fpe_pkg::REGION_SHIFT);
	localparam logic [fpe_pkg::INT_W-1:0] IRQ_RST_W = fpe_pkg::IRQ_RST;

	// ==========================================================
	// Declarations
	logic ap_valid_reg;
	logic ap_write_reg;
	logic ap_ok_reg;
	logic [7:0] ap_addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_word;
	logic [31:0] faddr_reg;
	logic [31:0] fdata_reg;
	logic [fpe_pkg::USEC_W-1:0] usec_reg;
	logic [fpe_pkg::INT_W-1:0] ris_reg;
	logic [fpe_pkg::INT_W-1:0] imask_reg;
	logic [fpe_pkg::INT_W-1:0] int_set;
	logic [NUM_REGIONS-1:0][1:0] prot_reg;
	logic commit_reg;
	logic fail_reg;
	logic deny_reg;
	fpe_pkg::fpe_state_t state_reg;
	logic [ADDR_W-1:0] fl_addr_reg;
	logic [31:0] fl_wdata_reg;
	logic fl_rd_reg;
	logic fl_prog_reg;
	logic fl_erase_reg;
	logic wr_en;
	logic wr_ctrl;
	logic wr_prot;
	logic do_erase;
	logic do_prog;
	logic erase_ok;
	logic prog_ok;
	logic prot_ok;
	logic cmd_fail;
	logic tmr_start;
	logic tmr_done;
	logic [DUR_W-1:0] tmr_dur;

	// ==========================================================
	// Helper functions
	function automatic logic in_range(input logic [31:0] a);
		return a[31:ADDR_W] == '0;
	endfunction : in_range

	// Protection of the 2 kB region holding an address
	function automatic fpe_pkg::fpe_prot_t prot_of(
		input logic [NUM_REGIONS-1:0][1:0] map,
		input logic [ADDR_W-1:0] a);
		logic [1:0] p;
		p = map[a[ADDR_W-1:fpe_pkg::REGION_SHIFT]];
		return (p == 2'h0) ? fpe_pkg::prot_unrestricted
			: (p == 2'h1) ? fpe_pkg::prot_no_modify
			: fpe_pkg::prot_fetch_only;
	endfunction : prot_of

	// Allowed only when the new setting is strictly tighter
	function automatic logic tighter(input fpe_pkg::fpe_prot_t cur,
		input logic [1:0] nxt);
		return (cur == fpe_pkg::prot_unrestricted && (nxt == 2'h1
			|| nxt == 2'h2)) || (cur == fpe_pkg::prot_no_modify
			&& nxt == 2'h2);
	endfunction : tighter

	// ==========================================================
	// Bus slave: address phase capture, zero wait states, always OKAY
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_ok_reg <= 1'b0;
			ap_addr_reg <= 8'h00;
			hrdata_reg <= 32'h00000000;
		end
		else
		begin
			ap_valid_reg <= hsel && htrans[1] && hready;
			ap_write_reg <= hwrite;
			ap_ok_reg <= (hsize == 3'h2) && (haddr[1:0] == 2'h0);
			ap_addr_reg <= haddr[7:0];
			if (hsel && htrans[1] && hready && !hwrite)
				hrdata_reg <= rd_word;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign wr_en = ap_valid_reg && ap_write_reg && ap_ok_reg;
	assign wr_ctrl = wr_en && ap_addr_reg == fpe_pkg::OFS_CTRL;
	assign wr_prot = wr_en && ap_addr_reg == fpe_pkg::OFS_PROT;

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		rd_word = 32'h00000000;
		if (haddr[7:0] == fpe_pkg::OFS_ADDR)
			rd_word = faddr_reg;
		else if (haddr[7:0] == fpe_pkg::OFS_DATA)
			rd_word = fdata_reg;
		else if (haddr[7:0] == fpe_pkg::OFS_CTRL)
		begin
			rd_word[fpe_pkg::STAT_BUSY] = busy;
			rd_word[fpe_pkg::STAT_FAIL] = fail_reg;
		end
		else if (haddr[7:0] == fpe_pkg::OFS_USEC)
			rd_word[fpe_pkg::USEC_W-1:0] = usec_reg;
		else if (haddr[7:0] == fpe_pkg::OFS_RIS)
			rd_word[fpe_pkg::INT_W-1:0] = ris_reg;
		else if (haddr[7:0] == fpe_pkg::OFS_IMASK)
			rd_word[fpe_pkg::INT_W-1:0] = imask_reg;
		else if (haddr[7:0] == fpe_pkg::OFS_MIS)
			rd_word[fpe_pkg::INT_W-1:0] = ris_reg & imask_reg;
		else if (haddr[7:0] == fpe_pkg::OFS_PROT)
			rd_word[1:0] = prot_of(prot_reg, faddr_reg[ADDR_W-1:0]);
	end

	// ==========================================================
	// Plain software registers
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			faddr_reg <= 32'h00000000;
			fdata_reg <= 32'h00000000;
			usec_reg <= fpe_pkg::USEC_RST;
			imask_reg <= IRQ_RST_W;
		end
		else if (wr_en)
		begin
			if (ap_addr_reg == fpe_pkg::OFS_ADDR)
				faddr_reg <= hwdata;
			else if (ap_addr_reg == fpe_pkg::OFS_DATA)
				fdata_reg <= hwdata;
			else if (ap_addr_reg == fpe_pkg::OFS_USEC)
				usec_reg <= hwdata[fpe_pkg::USEC_W-1:0];
			else if (ap_addr_reg == fpe_pkg::OFS_IMASK)
				imask_reg <= hwdata[fpe_pkg::INT_W-1:0];
		end
	end

	// ==========================================================
	// Command checks; erase and program commands while busy are ignored
	assign do_erase = wr_ctrl && hwdata[fpe_pkg::CTRL_ERASE]
		&& state_reg == fpe_pkg::st_idle;
	assign do_prog = wr_ctrl && hwdata[fpe_pkg::CTRL_PROG]
		&& !hwdata[fpe_pkg::CTRL_ERASE]
		&& state_reg == fpe_pkg::st_idle;
	assign erase_ok = in_range(faddr_reg)
		&& faddr_reg[fpe_pkg::BLOCK_SHIFT-1:0] == '0
		&& prot_of(prot_reg, faddr_reg[ADDR_W-1:0])
		== fpe_pkg::prot_unrestricted;
	assign prog_ok = in_range(faddr_reg)
		&& faddr_reg[fpe_pkg::WORD_SHIFT-1:0] == '0
		&& prot_of(prot_reg, faddr_reg[ADDR_W-1:0])
		== fpe_pkg::prot_unrestricted;
	assign prot_ok = in_range(faddr_reg) && tighter(
		prot_of(prot_reg, faddr_reg[ADDR_W-1:0]), hwdata[1:0]);
	assign cmd_fail = (do_erase && !erase_ok) || (do_prog && !prog_ok)
		|| (wr_prot && !prot_ok);

	// ==========================================================
	// Protection map: committed copy at reset, tightened live
	always_ff @(posedge clock)
	begin
		if (!nrst)
			prot_reg <= saved_prot;
		else if (wr_prot && prot_ok)
			prot_reg[faddr_reg[ADDR_W-1:fpe_pkg::REGION_SHIFT]]
				<= hwdata[1:0];
	end

	// One-way commit of the live map to nonvolatile storage
	always_ff @(posedge clock)
	begin
		if (!nrst)
			commit_reg <= 1'b0;
		else
			commit_reg <= wr_ctrl && hwdata[fpe_pkg::CTRL_COMMIT];
	end

	assign prot_commit = commit_reg;
	assign prot_commit_map = prot_reg;

	// Failure flag: set by a refused command, cleared by an accepted erase or program
	always_ff @(posedge clock)
	begin
		if (!nrst)
			fail_reg <= 1'b0;
		else if (cmd_fail)
			fail_reg <= 1'b1;
		else if (do_erase || do_prog)
			fail_reg <= 1'b0;
	end

	// ==========================================================
	// Read check: only instruction fetch may read a fetch-only region
	always_ff @(posedge clock)
	begin
		if (!nrst)
			deny_reg <= 1'b0;
		else
			deny_reg <= acc_valid && acc_kind != fpe_pkg::ACC_FETCH
				&& prot_of(prot_reg, acc_addr)
				== fpe_pkg::prot_fetch_only;
	end

	assign acc_deny = deny_reg;

	// ==========================================================
	// Operation sequencer and flash array strobes
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			state_reg <= fpe_pkg::st_idle;
			fl_addr_reg <= '0;
			fl_wdata_reg <= 32'hFFFFFFFF;
			fl_rd_reg <= 1'b0;
			fl_prog_reg <= 1'b0;
			fl_erase_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				fpe_pkg::st_idle:
				begin
					if (do_erase && erase_ok)
					begin
						state_reg <= fpe_pkg::st_busy_op;
						fl_addr_reg <= faddr_reg[ADDR_W-1:0];
						fl_wdata_reg <= 32'hFFFFFFFF;
						fl_erase_reg <= 1'b1;
					end
					else if (do_prog && prog_ok)
					begin
						state_reg <= fpe_pkg::st_rd_req;
						fl_addr_reg <= faddr_reg[ADDR_W-1:0];
						fl_rd_reg <= 1'b1;
					end
				end
				fpe_pkg::st_rd_req:
				begin
					state_reg <= fpe_pkg::st_rd_take;
					fl_rd_reg <= 1'b0;
				end
				fpe_pkg::st_rd_take:
				begin
					state_reg <= fpe_pkg::st_busy_op;
					fl_wdata_reg <= fl_rdata & fdata_reg;
					fl_prog_reg <= 1'b1;
				end
				default:
				begin
					if (tmr_done)
					begin
						state_reg <= fpe_pkg::st_idle;
						fl_prog_reg <= 1'b0;
						fl_erase_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	assign fl_addr = fl_addr_reg;
	assign fl_wdata = fl_wdata_reg;
	assign fl_rd = fl_rd_reg;
	assign fl_prog = fl_prog_reg;
	assign fl_erase = fl_erase_reg;
	assign busy = state_reg != fpe_pkg::st_idle;

	// ==========================================================
	// Pulse length from the clocks-per-microsecond setting
	assign tmr_start = (state_reg == fpe_pkg::st_idle && do_erase
		&& erase_ok) || state_reg == fpe_pkg::st_rd_take;
	assign tmr_dur = (state_reg == fpe_pkg::st_idle)
		? DUR_W'(ERASE_US) : DUR_W'(PROG_US);

	fpe_us_timer #(
		.DUR_W(DUR_W)
	) u_timer (
		.clock(clock),
		.nrst(nrst),
		.start(tmr_start),
		.usec_clks(usec_reg),
		.dur_us(tmr_dur),
		.done(tmr_done)
	);

	// ==========================================================
	// Interrupts: sticky sources, write one to clear, set wins
	always_comb
	begin
		int_set = '0;
		int_set[fpe_pkg::INT_DONE] = tmr_done
			&& state_reg == fpe_pkg::st_busy_op;
		int_set[fpe_pkg::ACCESS_MISC_IRQ] = cmd_fail || deny_reg;
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			ris_reg <= IRQ_RST_W;
		else if (wr_en && ap_addr_reg == fpe_pkg::OFS_RIS)
			ris_reg <= (ris_reg & ~hwdata[fpe_pkg::INT_W-1:0])
				| int_set;
		else
			ris_reg <= ris_reg | int_set;
	end

	assign irq = |(ris_reg & imask_reg);

endmodule : fpe_ctrl

/* File: bench/fpe_ctrl_monitor.sv */
// ==========================================================
// Port checker for the flash controller
module fpe_ctrl_monitor #(
	parameter int ADDR_W = 15
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic acc_valid,
	input wire logic [1:0] acc_kind,
	input wire logic acc_deny,
	input wire logic [ADDR_W-1:0] fl_addr,
	input wire logic [31:0] fl_wdata,
	input wire logic [31:0] fl_rdata,
	input wire logic fl_rd,
	input wire logic fl_prog,
	input wire logic fl_erase,
	input wire logic prot_commit,
	input wire logic busy
);
	logic rd_q;
	logic [31:0] old_q;

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	// ==========================================================
	// Old word as the array returned it before a program
	always_ff @(posedge clock)
	begin
		rd_q <= fl_rd;
		if (rd_q)
			old_q <= fl_rdata;
	end

	// ==========================================================
	// Strobes towards the array and the read-check deny
	chk_erase_ones: assert property (
		fl_erase |-> fl_wdata == 32'hFFFFFFFF)
		else $error("erase data not all ones");
	chk_erase_block: assert property (
		fl_erase |-> fl_addr[9:0] == 10'h000)
		else $error("erase address not on a block");
	chk_erase_hold: assert property (
		fl_erase && $past(fl_erase) |-> $stable(fl_addr))
		else $error("erase address moved");
	chk_prog_order: assert property (
		fl_rd |-> ##2 fl_prog)
		else $error("program did not follow read");
	chk_prog_clears: assert property (
		fl_prog |-> (fl_wdata & ~old_q) == 32'h00000000)
		else $error("program sets a cleared bit");
	chk_strobe_busy: assert property (
		(fl_prog || fl_erase) |-> busy)
		else $error("strobe without busy");
	chk_strobe_excl: assert property (
		!(fl_prog && fl_erase))
		else $error("program and erase together");
	chk_busy_end: assert property (
		$fell(busy) |-> !fl_prog && !fl_erase)
		else $error("busy fell with strobe high");
	chk_fetch_ok: assert property (
		acc_valid && acc_kind == fpe_pkg::ACC_FETCH |=> !acc_deny)
		else $error("fetch was denied");
	chk_deny_cause: assert property (
		acc_deny |-> $past(acc_valid) && $past(acc_kind) != 2'h0)
		else $error("deny without a non-fetch read");

	// ==========================================================
	// Main scenarios reached
	cov_erase: cover property ($rose(fl_erase));
	cov_prog: cover property ($rose(fl_prog));
	cov_deny: cover property (acc_deny);
	cov_commit: cover property (prot_commit);
endmodule : fpe_ctrl_monitor

bind fpe_ctrl fpe_ctrl_monitor #(.ADDR_W(ADDR_W)) u_mon (.clock(clock),
	.nrst(nrst), .acc_valid(acc_valid), .acc_kind(acc_kind),
	.acc_deny(acc_deny), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
	.fl_rdata(fl_rdata), .fl_rd(fl_rd), .fl_prog(fl_prog),
	.fl_erase(fl_erase), .prot_commit(prot_commit), .busy(busy));

/* File: bench/fpe_flash_model.sv */
// ==========================================================
// Behavioural flash array on the far side of the controller
module fpe_flash_model #(
	parameter int ADDR_W = 15
) (
	input wire logic clock,
	input wire logic [ADDR_W-1:0] fl_addr,
	input wire logic [31:0] fl_wdata,
	input wire logic fl_rd,
	input wire logic fl_prog,
	input wire logic fl_erase,
	output logic [31:0] fl_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:2**(ADDR_W-2)-1];

	// Array starts with every word at zero
	initial
	begin
		foreach (mem[i])
			mem[i] = 32'h00000000;
		fl_rdata = 32'h00000000;
	end

	// Erase, program and read of the array
	always @(posedge clock)
	begin
		if (fl_erase)
			for (int i = 0; i < 256; i++)
				mem[{fl_addr[ADDR_W-1:10], i[7:0]}] <= 32'hFFFFFFFF;
		if (fl_prog)
			mem[fl_addr[ADDR_W-1:2]] <= mem[fl_addr[ADDR_W-1:2]] & fl_wdata;
		if (fl_rd)
			fl_rdata <= mem[fl_addr[ADDR_W-1:2]];
		else
			fl_rdata <= ~fl_rdata; // Stale data keeps toggling
	end
endmodule : fpe_flash_model

/* File: bench/tb_top.sv */
// ==========================================================
// Register-level test of the flash controller
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PUS = 2;
	localparam int EUS = 3;
	logic clock, nrst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, fl_wdata, fl_rdata;
	logic [31:0] saved_prot, prot_commit_map, cmap;
	logic [1:0] htrans, acc_kind;
	logic [2:0] hsize;
	logic [14:0] acc_addr, fl_addr;
	logic acc_valid, acc_deny, fl_rd, fl_prog, fl_erase;
	logic prot_commit, busy, irq;
	int fails, n_tests, scyc;

	assign hready = hreadyout;

	// Controller and flash array
	fpe_ctrl #(.PROG_US(PUS), .ERASE_US(EUS)) DUT (.clock, .nrst, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
		.hresp, .hrdata, .acc_valid, .acc_addr, .acc_kind, .acc_deny,
		.fl_addr, .fl_wdata, .fl_rdata, .fl_rd, .fl_prog, .fl_erase,
		.saved_prot, .prot_commit, .prot_commit_map, .busy, .irq);
	fpe_flash_model PM (.clock, .fl_addr, .fl_wdata, .fl_rd, .fl_prog,
		.fl_erase, .fl_rdata);

	// Clock, strobe length and committed map capture
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) if (fl_erase || fl_prog) scyc <= scyc + 1;
	always @(posedge clock) if (prot_commit) cmap <= prot_commit_map;

	// ==========================================================
	// Bus and compare tasks
	task automatic end_of_test();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wait_rdy();
		int k;
		k = 0;
		@(posedge clock);
		while (hready !== 1'b1)
		begin
			k++;
			if (k > 50)
			begin
				fails++;
				end_of_test();
			end
			@(posedge clock);
		end
	endtask : wait_rdy

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(q, e);
	endtask : rdc

	task automatic wait_idle();
		logic [31:0] q;
		int k;
		k = 0;
		q = 32'h00000001;
		while (q[0] !== 1'b0)
		begin
			k++;
			if (k > 100)
			begin
				fails++;
				end_of_test();
			end
			bus(1'b0, fpe_pkg::OFS_CTRL, 32'h00000000, q);
		end
	endtask : wait_idle

	task automatic op(input logic [31:0] a, input logic [31:0] c);
		wr(fpe_pkg::OFS_ADDR, a);
		scyc = 0;
		wr(fpe_pkg::OFS_CTRL, c);
		wait_idle();
	endtask : op

	task automatic acc(input logic [14:0] a, input logic [1:0] k,
		input logic e);
		@(posedge clock);
		acc_valid <= 1'b1;
		acc_addr <= a;
		acc_kind <= k;
		@(posedge clock);
		acc_valid <= 1'b0;
		@(negedge clock);
		chk({31'h0, acc_deny}, {31'h0, e});
	endtask : acc

	task automatic do_reset();
		@(posedge clock);
		nrst <= 1'b0;
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
	endtask : do_reset

	// ==========================================================
	// Main sequence
	initial
	begin
		{nrst, hsel, hwrite, acc_valid, htrans, acc_kind} = '0;
		{haddr, hwdata, saved_prot, acc_addr} = '0;
		hsize = 3'h2;
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		rdc(fpe_pkg::OFS_USEC, 32'h00000064);
		wr(fpe_pkg::OFS_USEC, 32'h00000004);
		wr(fpe_pkg::OFS_DATA, 32'h00000000);
		wr(fpe_pkg::OFS_ADDR, 32'h00000400);
		scyc = 0;
		wr(fpe_pkg::OFS_CTRL, 32'h00000001);
		rdc(fpe_pkg::OFS_CTRL, 32'h00000001);
		wr(fpe_pkg::OFS_CTRL, 32'h00000002);
		wait_idle();
		chk(scyc, EUS * 4);
		chk(PM.mem[13'h100], 32'hFFFFFFFF);
		chk(PM.mem[13'h1FF], 32'hFFFFFFFF);
		chk(PM.mem[13'h200], 32'h00000000);
		rdc(fpe_pkg::OFS_RIS, 32'h00000001);
		chk({31'h0, irq}, 32'h0);
		wr(fpe_pkg::OFS_IMASK, 32'h00000001);
		@(negedge clock);
		chk({31'h0, irq}, 32'h1);
		rdc(fpe_pkg::OFS_MIS, 32'h00000001);
		wr(fpe_pkg::OFS_RIS, 32'h00000001);
		@(negedge clock);
		chk({31'h0, irq}, 32'h0);
		wr(fpe_pkg::OFS_USEC, 32'h00000003);
		wr(fpe_pkg::OFS_DATA, 32'hF0F0FFFF);
		op(32'h00000404, 32'h00000002);
		chk(scyc, PUS * 3);
		wr(fpe_pkg::OFS_DATA, 32'h0FFF00FF);
		op(32'h00000404, 32'h00000002);
		chk(PM.mem[13'h101], 32'h00F000FF);
		wr(fpe_pkg::OFS_ADDR, 32'h00000800);
		wr(fpe_pkg::OFS_PROT, 32'h00000001);
		op(32'h00000C00, 32'h00000001);
		rdc(fpe_pkg::OFS_CTRL, 32'h00000002);
		chk(PM.mem[13'h300], 32'h00000000);
		rdc(fpe_pkg::OFS_RIS, 32'h00000003);
		rdc(fpe_pkg::OFS_MIS, 32'h00000001);
		wr(fpe_pkg::OFS_RIS, 32'h00000002);
		rdc(fpe_pkg::OFS_RIS, 32'h00000001);
		op(32'h00000404 + 32'h00000001, 32'h00000001);
		rdc(fpe_pkg::OFS_CTRL, 32'h00000002);
		chk(scyc, 0);
		rdc(fpe_pkg::OFS_RIS, 32'h00000003);
		wr(fpe_pkg::OFS_ADDR, 32'h00000800);
		wr(fpe_pkg::OFS_PROT, 32'h00000000);
		rdc(fpe_pkg::OFS_PROT, 32'h00000001);
		wr(fpe_pkg::OFS_PROT, 32'h00000002);
		rdc(fpe_pkg::OFS_PROT, 32'h00000002);
		op(32'h00000804, 32'h00000002);
		rdc(fpe_pkg::OFS_CTRL, 32'h00000002);
		chk(scyc, 0);
		acc(15'h0804, fpe_pkg::ACC_DATA, 1'b1);
		acc(15'h0804, fpe_pkg::ACC_DEBUG, 1'b1);
		acc(15'h0804, fpe_pkg::ACC_FETCH, 1'b0);
		acc(15'h0404, fpe_pkg::ACC_DATA, 1'b0);
		do_reset();
		wr(fpe_pkg::OFS_ADDR, 32'h00000800);
		rdc(fpe_pkg::OFS_PROT, 32'h00000000);
		wr(fpe_pkg::OFS_PROT, 32'h00000002);
		wr(fpe_pkg::OFS_CTRL, 32'h00000004);
		repeat (2) @(posedge clock);
		chk(cmap, 32'h00000008);
		saved_prot <= cmap;
		do_reset();
		wr(fpe_pkg::OFS_ADDR, 32'h00000800);
		rdc(fpe_pkg::OFS_PROT, 32'h00000002);
		end_of_test();
	end
endmodule : tb_top
